// >>> core/tce_pkg.sv
// Constants and types for the timer channel event flag block
`default_nettype none
package tce_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS      = 8'h00;
    localparam logic [7:0] MOD_OFS       = 8'h04;
    localparam logic [7:0] COUNT_OFS     = 8'h08;
    localparam logic [7:0] FLAG_OFS      = 8'h0c;
    localparam logic [7:0] IRQ_EN_OFS    = 8'h10;
    localparam logic [7:0] CHAN_BASE_OFS = 8'h20;
    localparam logic [7:0] CHAN_VAL_OFS  = 8'h04;
    localparam int         CHAN_SHIFT    = 3;
    // ==========================================================
    // Field positions and reset values
    localparam int          CTRL_RUN_BIT    = 0;
    localparam int          CTRL_CENTER_BIT = 1;
    localparam int          CFG_MODE_LSB    = 0;
    localparam int          CFG_EDGE_LSB    = 2;
    localparam int          EDGE_RISE_BIT   = 0;
    localparam int          EDGE_FALL_BIT   = 1;
    localparam logic [15:0] MOD_RESET       = 16'h0000;
    localparam logic [15:0] VAL_RESET       = 16'h0000;
    localparam int          CHANNELS        = 2;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    // ==========================================================
    // Channel mode and configuration
    typedef enum logic [1:0] {
        MODE_CAPTURE,
        MODE_COMPARE,
        MODE_EDGE_PWM,
        MODE_SPARE
    } tce_mode_type;
    typedef struct packed {
        logic [1:0]   edge_level_select;
        tce_mode_type mode;
    } tce_chan_cfg_type;
endpackage
`default_nettype wire

// >>> core/tce_timer_channel.sv
// Timer channel event flags with AXI4-Lite register slave
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`default_nettype none
module tce_timer_channel
    import tce_pkg::*;
#(
    parameter int N = tce_pkg::CHANNELS
)(
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [N-1:0] chan_pin,
    output var  logic         irq,
    input  wire logic [7:0]   s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output var  logic         s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output var  logic         s_axi_wready,
    output var  logic [1:0]   s_axi_bresp,
    output var  logic         s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [7:0]   s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output var  logic         s_axi_arready,
    output var  logic [31:0]  s_axi_rdata,
    output var  logic [1:0]   s_axi_rresp,
    output var  logic         s_axi_rvalid,
    input  wire logic         s_axi_rready
);
    import tce_pkg::*;
    // ==========================================================
    // Helpers
    // Merge bus bytes into a 16-bit register under strobes
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction
    // Channel window hit for an address
    function automatic logic chan_hit(input logic [7:0] a);
        chan_hit = (a >= CHAN_BASE_OFS) && (a < CHAN_BASE_OFS + 8'((N) << CHAN_SHIFT));
    endfunction
    function automatic int chan_num(input logic [7:0] a);
        chan_num = int'((a - CHAN_BASE_OFS) >> CHAN_SHIFT);
    endfunction
    // ==========================================================
    // State
    logic                   run_reg, center_reg;
    logic [15:0]            mod_reg, count_reg;
    logic                   down_reg;
    logic [N-1:0]           flag_reg, armed_reg, irq_en_reg;
    tce_chan_cfg_type       cfg_reg [N];
    logic [15:0]            val_reg [N];
    logic [N-1:0]           pin_s1_reg, pin_s2_reg, pin_s3_reg;
    logic [7:0]             aw_addr_reg, ar_addr_reg;
    logic [31:0]            w_data_reg;
    logic [3:0]             w_strb_reg;
    logic                   aw_full_reg, w_full_reg;
    logic [N-1:0]           event_hit, match, rise, fall;
    logic                   wr_go, rd_go, flag_rd, flag_wr;
    logic [31:0]            rd_next;
    logic                   rd_err;
    // ==========================================================
    // Pin synchroniser; edges seen only past the second stage
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            {pin_s3_reg, pin_s2_reg, pin_s1_reg} <= '0;
        else
            {pin_s3_reg, pin_s2_reg, pin_s1_reg} <= {pin_s2_reg, pin_s1_reg, chan_pin};
    end
    assign rise = pin_s2_reg & ~pin_s3_reg;
    assign fall = ~pin_s2_reg & pin_s3_reg;
    // ==========================================================
    // Main counter: up to modulus, or up/down when center-aligned
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_reg <= 16'h0000;
            down_reg  <= 1'b0;
        end
        else if (!run_reg)
            down_reg <= 1'b0;
        else if (center_reg)
        begin
            if (!down_reg && count_reg == mod_reg)
            begin
                down_reg  <= 1'b1;
                count_reg <= count_reg - 16'h0001;
            end
            else if (down_reg && count_reg == 16'h0000)
            begin
                down_reg  <= 1'b0;
                count_reg <= 16'h0001;
            end
            else
                count_reg <= down_reg ? count_reg - 16'h0001 : count_reg + 16'h0001;
        end
        else
        begin
            // Modulus zero lets the counter run free through the wrap
            down_reg  <= 1'b0;
            count_reg <= (mod_reg != 16'h0000 && count_reg == mod_reg) ? 16'h0000
                                                                       : count_reg + 16'h0001;
        end
    end
    // ==========================================================
    // Channel events per mode; a stopped counter matches nothing
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            match[i] = run_reg && (count_reg == val_reg[i]);
            if (center_reg)
                event_hit[i] = match[i];
            else if (cfg_reg[i].mode == MODE_CAPTURE)
                event_hit[i] = (cfg_reg[i].edge_level_select[EDGE_RISE_BIT] & rise[i])
                             | (cfg_reg[i].edge_level_select[EDGE_FALL_BIT] & fall[i]);
            else if (cfg_reg[i].mode == MODE_SPARE)
                event_hit[i] = 1'b0;
            else
                event_hit[i] = match[i];
        end
    end
    // ==========================================================
    // Bus handshake decode
    assign wr_go   = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign rd_go   = s_axi_arvalid && s_axi_arready;
    assign flag_rd = rd_go && s_axi_araddr == FLAG_OFS;
    assign flag_wr = wr_go && aw_addr_reg == FLAG_OFS && w_strb_reg[0];
    // ==========================================================
    // Flags: set wins over clear; clear needs an armed read first
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            {flag_reg, armed_reg} <= '0;
        else
        begin
            for (int i = 0; i < N; i++)
            begin
                if (event_hit[i])
                begin
                    flag_reg[i]  <= 1'b1;
                    armed_reg[i] <= 1'b0;
                end
                else if (flag_wr)
                begin
                    if (armed_reg[i] && !w_data_reg[i])
                        flag_reg[i] <= 1'b0;
                    armed_reg[i] <= 1'b0;
                end
                else if (flag_rd && flag_reg[i])
                    armed_reg[i] <= 1'b1;
            end
        end
    end
    // ==========================================================
    // Level interrupt, registered so the pin comes from a flop
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            irq <= 1'b0;
        else
            irq <= |(flag_reg & irq_en_reg);
    end
    // ==========================================================
    // Software registers; capture beats a same-cycle value write
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            {run_reg, center_reg} <= 2'b00;
            mod_reg    <= MOD_RESET;
            irq_en_reg <= '0;
            for (int i = 0; i < N; i++)
            begin
                cfg_reg[i] <= '0;
                val_reg[i] <= VAL_RESET;
            end
        end
        else
        begin
            if (wr_go && w_strb_reg[0] && aw_addr_reg == CTRL_OFS)
                {center_reg, run_reg} <= {w_data_reg[CTRL_CENTER_BIT], w_data_reg[CTRL_RUN_BIT]};
            if (wr_go && aw_addr_reg == MOD_OFS)
                mod_reg <= merge16(mod_reg, w_data_reg, w_strb_reg);
            if (wr_go && w_strb_reg[0] && aw_addr_reg == IRQ_EN_OFS)
                irq_en_reg <= w_data_reg[N-1:0];
            for (int i = 0; i < N; i++)
            begin
                if (wr_go && w_strb_reg[0] && chan_hit(aw_addr_reg) && chan_num(aw_addr_reg) == i
                    && aw_addr_reg[CHAN_SHIFT-1:0] == 3'h0)
                    cfg_reg[i] <= tce_chan_cfg_type'(w_data_reg[3:0]);
                if (!center_reg && cfg_reg[i].mode == MODE_CAPTURE && event_hit[i])
                    val_reg[i] <= count_reg;
                else if (wr_go && chan_hit(aw_addr_reg) && chan_num(aw_addr_reg) == i
                         && aw_addr_reg[CHAN_SHIFT-1:0] == CHAN_VAL_OFS[2:0])
                    val_reg[i] <= merge16(val_reg[i], w_data_reg, w_strb_reg);
            end
        end
    end
    // ==========================================================
    // Write channels: address and data taken in either order
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            {aw_full_reg, w_full_reg} <= 2'b00;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
            {s_axi_awready, s_axi_wready, s_axi_bvalid} <= 3'b000;
            s_axi_bresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_full_reg && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_full_reg && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_reg inside {CTRL_OFS, MOD_OFS, FLAG_OFS, IRQ_EN_OFS}
                                 || (chan_hit(aw_addr_reg) && aw_addr_reg[1:0] == 2'h0))
                                ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_full_reg  <= 1'b0;
                w_full_reg   <= 1'b0;
            end
        end
    end
    // ==========================================================
    // Read mux; channel words are config then value
    always_comb
    begin
        rd_next = 32'h0000_0000;
        rd_err  = 1'b0;
        unique case (s_axi_araddr)
            CTRL_OFS:   rd_next = {30'h0, center_reg, run_reg};
            MOD_OFS:    rd_next = {16'h0000, mod_reg};
            COUNT_OFS:  rd_next = {16'h0000, count_reg};
            FLAG_OFS:   rd_next[N-1:0] = flag_reg;
            IRQ_EN_OFS: rd_next[N-1:0] = irq_en_reg;
            default:
            begin
                if (chan_hit(s_axi_araddr) && s_axi_araddr[CHAN_SHIFT-1:0] == 3'h0)
                    rd_next = {28'h0, cfg_reg[chan_num(s_axi_araddr)]};
                else if (chan_hit(s_axi_araddr) && s_axi_araddr[1:0] == 2'h0)
                    rd_next = {16'h0000, val_reg[chan_num(s_axi_araddr)]};
                else
                    rd_err = 1'b1;
            end
        endcase
    end
    // Read channel: one read at a time, answer the cycle after
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            {s_axi_arready, s_axi_rvalid} <= 2'b00;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !rd_go;
            if (rd_go)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_next;
                s_axi_rresp  <= rd_err ? RESP_SLVERR : RESP_OKAY;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
    // ==========================================================
    // Checks on channel 0
    sequence s_armed;
        flag_rd && flag_reg[0];
    endsequence
    sequence s_zero_write;
        flag_wr && !w_data_reg[0] && !event_hit[0];
    endsequence
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    chk_capture_edge_flag: assert property (
        !center_reg && cfg_reg[0].mode == MODE_CAPTURE && rise[0]
        && cfg_reg[0].edge_level_select == 2'h1 |=> flag_reg[0])
        else $error("rising edge did not set flag");
    chk_capture_off: assert property (
        !center_reg && cfg_reg[0].mode == MODE_CAPTURE
        && cfg_reg[0].edge_level_select == 2'h0 |-> !event_hit[0])
        else $error("capture fired with edges off");
    chk_compare_match: assert property (
        run_reg && !center_reg && cfg_reg[0].mode == MODE_COMPARE
        && count_reg == val_reg[0] |=> flag_reg[0])
        else $error("compare match did not set flag");
    chk_edge_pwm_match: assert property (
        run_reg && !center_reg && cfg_reg[0].mode == MODE_EDGE_PWM
        && count_reg == val_reg[0] |=> flag_reg[0])
        else $error("pwm match did not set flag");
    chk_center_both: assert property (
        run_reg && center_reg && count_reg == val_reg[0] |=> flag_reg[0])
        else $error("center match did not set flag");
    chk_flag_only_clear: assert property (
        $fell(flag_reg[0]) |-> $past(flag_wr) && $past(armed_reg[0]))
        else $error("flag fell without two-step clear");
    chk_read_arms: assert property (
        s_armed ##0 (!event_hit[0] && !flag_wr) |=> armed_reg[0])
        else $error("read of set flag did not arm clear");
    chk_two_step_clear: assert property (
        armed_reg[0] ##0 s_zero_write |=> !flag_reg[0])
        else $error("two-step clear failed");
    chk_irq_level: assert property (
        flag_reg[0] && irq_en_reg[0] |=> irq)
        else $error("enabled flag did not raise irq");
    chk_capture_latch: assert property (
        !center_reg && cfg_reg[0].mode == MODE_CAPTURE && event_hit[0]
        |=> val_reg[0] == $past(count_reg) && flag_reg[0])
        else $error("capture did not latch counter");
endmodule
`default_nettype wire

// >>> bench/tce_pin_model.sv
// Stand-in for the external signal that drives the timer channel pins
`timescale 1ns/100ps
`default_nettype none
module tce_pin_model #(
    parameter int N     = 2,
    parameter int DELAY = 3
)(
    input  wire logic         clk,
    input  wire logic [N-1:0] level_cmd,
    output var  logic [N-1:0] chan_pin
);
    // ==========================================================
    // Delay line
    // The outside source answers some cycles after it is told, never at once
    logic [DELAY-1:0][N-1:0] pipe = '0;
    always_ff @(posedge clk)
    begin
        pipe[0] <= level_cmd;
        for (int i = 1; i < DELAY; i++)
            pipe[i] <= pipe[i-1];
    end
    assign chan_pin = pipe[DELAY-1];
endmodule
`default_nettype wire

// >>> bench/tce_timer_channel_test.sv
// Self-checking bench for the timer channel event flag block
`timescale 1ns/100ps
`default_nettype none
module tce_timer_channel_test;
    import tce_pkg::*;
    // ==========================================================
    // Signals and counters
    logic        clk = 1'b0;
    logic        reset_n;
    logic [1:0]  pin_cmd;
    logic [1:0]  chan_pin;
    logic        irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    int          num_errors = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          t0, gap;
    // ==========================================================
    // Clock, cycle count and instances
    always #50 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    tce_pin_model #(.N(2), .DELAY(3)) i_tce_pin_model (.clk, .level_cmd(pin_cmd), .chan_pin);
    tce_timer_channel #(.N(2)) i_tce_timer_channel (
        .clk, .reset_n, .chan_pin, .irq,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready
    );
    // ==========================================================
    // Comparison, bus tasks and address helpers
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Handshakes are judged at the negedge; ready is registered, so it holds to the next edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic aw_hs, w_hs, got;
        got = 1'b0;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!got)
        begin
            @(negedge clk);
            aw_hs = s_axi_awvalid & s_axi_awready;
            w_hs  = s_axi_wvalid & s_axi_wready;
            got   = s_axi_bvalid;
            resp  = s_axi_bresp;
            @(posedge clk);
            if (aw_hs) s_axi_awvalid <= 1'b0;
            if (w_hs) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic ar_hs, got;
        got = 1'b0;
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (!got)
        begin
            @(negedge clk);
            ar_hs = s_axi_arvalid & s_axi_arready;
            got   = s_axi_rvalid;
            d     = s_axi_rdata;
            resp  = s_axi_rresp;
            @(posedge clk);
            if (ar_hs) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        wr(a, d, r);
    endtask
    task automatic chk_reg(input string name, input logic [7:0] a, input logic [31:0] exp);
        rd(a, v, r);
        chk(name, v, exp);
    endtask
    // Polling reads also arm the clear of any bit they see set
    task automatic wait_flag(input logic [31:0] mask);
        int n;
        n = 0;
        v = '0;
        while ((v & mask) == 0 && n < 60)
        begin
            rd(FLAG_OFS, v, r);
            n++;
        end
    endtask
    function automatic logic [7:0] cfg_a(input int ch);
        return CHAN_BASE_OFS + 8'(ch << CHAN_SHIFT);
    endfunction
    function automatic logic [7:0] val_a(input int ch);
        return cfg_a(ch) + CHAN_VAL_OFS;
    endfunction
    task automatic end_sim;
        $display("Checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ==========================================================
    // Watchdog, well beyond the thousand or so cycles the tests need
    initial
    begin
        repeat (30000) @(posedge clk);
        num_errors++;
        end_sim();
    end
    // ==========================================================
    // Test sequence
    initial
    begin
        reset_n       = 1'b0;
        pin_cmd       = 2'h0;
        s_axi_awaddr  = 8'h00;
        s_axi_araddr  = 8'h00;
        s_axi_wdata   = 32'h0;
        s_axi_wstrb   = 4'hf;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid  = 1'b0;
        s_axi_bready  = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready  = 1'b0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk_reg("flag_rst", FLAG_OFS, 32'h0);
        chk_reg("mod_rst", MOD_OFS, {16'h0, MOD_RESET});
        rd(8'h3c, v, r);
        chk("bad_rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
        chk("bad_rdata", v, 32'h0);
        wr(8'h3c, 32'h1, r);
        chk("bad_bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
        // Every edge select on channel 0; counter parked at zero, so capture loads zero
        for (int e = 0; e < 4; e++)
        begin
            wreg(cfg_a(0), 32'(e << CFG_EDGE_LSB));
            wreg(val_a(0), 32'h1234);
            pin_cmd[0] <= 1'b1;
            repeat (10) @(posedge clk);
            chk_reg("cap_rise", FLAG_OFS, {31'h0, e[EDGE_RISE_BIT]});
            wreg(FLAG_OFS, 32'h0);
            pin_cmd[0] <= 1'b0;
            repeat (10) @(posedge clk);
            chk_reg("cap_fall", FLAG_OFS, {31'h0, e[EDGE_FALL_BIT]});
            wreg(FLAG_OFS, 32'h0);
            chk_reg("cap_val", val_a(0), (e == 0) ? 32'h1234 : 32'h0);
        end
        // Clearing needs a read first; a fresh event between the steps restarts it
        wreg(cfg_a(0), 32'h1 << (CFG_EDGE_LSB + EDGE_RISE_BIT));
        pin_cmd[0] <= 1'b1;
        repeat (10) @(posedge clk);
        wreg(FLAG_OFS, 32'h0);
        chk_reg("clr_noread", FLAG_OFS, 32'h1);
        wreg(FLAG_OFS, 32'h1);
        chk_reg("clr_one", FLAG_OFS, 32'h1);
        pin_cmd[0] <= 1'b0;
        repeat (10) @(posedge clk);
        chk_reg("clr_arm", FLAG_OFS, 32'h1);
        pin_cmd[0] <= 1'b1;
        repeat (10) @(posedge clk);
        wreg(FLAG_OFS, 32'h0);
        chk_reg("clr_restart", FLAG_OFS, 32'h1);
        wreg(FLAG_OFS, 32'h0);
        chk_reg("clr_done", FLAG_OFS, 32'h0);
        wreg(cfg_a(0), 32'(MODE_SPARE));
        // Compare, edge PWM and center PWM on channel 1; only center matches twice a period
        wreg(IRQ_EN_OFS, 32'h2);
        wreg(MOD_OFS, 32'h40);
        wreg(val_a(1), 32'h8);
        for (int m = 1; m < 4; m++)
        begin
            wreg(CTRL_OFS, 32'h0);
            rd(FLAG_OFS, v, r);
            wreg(FLAG_OFS, 32'h0);
            @(negedge clk);
            chk("irq_idle", {31'h0, irq}, 32'h0);
            wreg(cfg_a(0), 32'((m == 1) ? MODE_COMPARE : (m == 2) ? MODE_EDGE_PWM : MODE_SPARE));
            wreg(cfg_a(1), 32'((m == 1) ? MODE_COMPARE : MODE_EDGE_PWM));
            wreg(CTRL_OFS, (m == 3) ? 32'h3 : 32'h1);
            wait_flag(32'h2);
            chk("match_flag", v & 32'h2, 32'h2);
            @(negedge clk);
            chk("irq_set", {31'h0, irq}, 32'h1);
            t0 = cyc;
            gap = 1000;
            wreg(FLAG_OFS, 32'h0);
            for (int k = 0; k < 2; k++)
            begin
                wait_flag(32'h2);
                if (cyc - t0 < gap) gap = cyc - t0;
                t0 = cyc;
                wreg(FLAG_OFS, 32'h0);
            end
            chk("match_gap", 32'(gap < 50), 32'(m == 3));
        end
        // Masking holds the request low while the flag stays set
        wait_flag(32'h2);
        wreg(IRQ_EN_OFS, 32'h0);
        @(negedge clk);
        chk("irq_mask", {31'h0, irq}, 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire
